/* File: core/aux_gpio_consts.vh */
/*
 * constants for the auxiliary pin configuration and watchdog block:
 * register indices, reset values, field positions and timing counts.
 * assumes an avalon-mm slave with 32-bit data and a 20 MHz clock.
 */
`ifndef AUX_GPIO_CONSTS_VH
`define AUX_GPIO_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_PIN_21_CONFIG      8'he9
`define IDX_PIN_22_CONFIG      8'hea
`define IDX_PIN_23_CONFIG      8'heb
`define IDX_PIN_24_CONFIG      8'hec
`define IDX_PIN_25_CONFIG      8'hed
`define IDX_RESERVED_SLOT      8'hee
`define IDX_COMBINED_IRQ_B     8'hef
`define IDX_COMBINED_IRQ_A     8'hf0
`define IDX_DECODER_STROBE_EN  8'hf1
`define IDX_WD_TIMEOUT_VALUE   8'hf2
`define IDX_WD_CONFIG          8'hf3
`define IDX_WD_CONTROL         8'hf4
`define IDX_DEVICE_ACTIVATE    8'h30

`define PIN_CONFIG_RESET       8'h01
`define REG_RESET_ZERO         8'h00

// pin configuration fields
`define PIN_DIR_BIT            0
`define PIN_POL_BIT            1
`define PIN_IRQ_EN_BIT         2
`define PIN_ALT_BIT            3
`define PIN_OC_BIT             7

// combined interrupt fields
`define CIRQ_FILTER_BIT        3
`define IRQ_MAP_LSB            4

// decoder/strobe enable fields
`define DEC_ADDR_EN_BIT        0
`define DEC_WSTB_EN_BIT        1
`define DEC_UNIT_SEL_BIT       7

// watchdog config fields
`define WCFG_GAME_BIT          0
`define WCFG_KBD_BIT           1
`define WCFG_MOUSE_BIT         2
`define WCFG_LED_BIT           3

// watchdog control fields
`define WCTL_STATUS_BIT        0
`define WCTL_LED_BIT           1
`define WCTL_FORCE_BIT         2
`define WCTL_KRST_EN_BIT       3

// timing
`define CLK_HZ                 20000000
`define UNIT_SHORT_MS          250
`define UNIT_LONG_MS           1000
`define LED_HALF_MS            500
`define DEBOUNCE_US            100

`endif

/* File: core/aux_gpio_and_watchdog_timer.v */
/*
 * auxiliary pin configuration and watchdog timer, one avalon-mm slave.
 * assumes all inputs synchronous to mclk_i; host irq lines are driven as a
 * 16-bit level vector (bit n = line n, bit 0 unused).
 */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "aux_gpio_consts.vh"

module aux_gpio_and_watchdog_timer #(
    parameter integer UNIT_SHORT_CYC = `CLK_HZ / 1000 * `UNIT_SHORT_MS,
    parameter integer UNIT_LONG_CYC  = `CLK_HZ / 1000 * `UNIT_LONG_MS,
    parameter integer LED_HALF_CYC   = `CLK_HZ / 1000 * `LED_HALF_MS,
    parameter integer DEBOUNCE_CYC   = `CLK_HZ / 1000000 * `DEBOUNCE_US
) (
    input  wire        mclk_i,
    input  wire        resetn_i,
    input  wire [9:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    output reg  [1:0]  avs_response_o,
    input  wire [4:0]  pin_in_i,
    input  wire [4:0]  pin_data_i,
    output reg  [4:0]  pin_out_o,
    output reg  [4:0]  pin_oe_o,
    output reg  [4:0]  pin_rd_o,
    input  wire        address_line_20_gate_i,
    input  wire        game_port_access_i,
    input  wire        keyboard_irq_i,
    input  wire        mouse_irq_i,
    input  wire        keyboard_reset_output_i,
    input  wire        general_address_hit_i,
    input  wire        general_write_hit_i,
    output reg         general_address_decoder_o,
    output reg         general_write_strobe_o,
    output reg         power_indicator_led_o,
    output reg  [15:0] host_irq_o
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RESP = 2'b10;
    localparam [1:0] RESP_OK  = 2'b00;
    localparam [1:0] RESP_ERR = 2'b10;

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    reg [7:0]  pin_cfg_q [0:4];
    reg [7:0]  cirq_b_q;
    reg [7:0]  cirq_a_q;
    reg [7:0]  dec_en_q;
    reg [7:0]  wd_val_q;
    reg [7:0]  wd_cfg_q;
    reg [3:0]  wd_ctl_q;
    reg        activate_q;
    reg [1:0]  state_q;

    wire [7:0] idx     = avs_address_i[9:2];
    // a write lands on the edge at which the master sees waitrequest low
    wire       wr_go   = avs_write_i && state_q == ST_RESP && avs_byteenable_i[0];
    wire       known   = (idx >= `IDX_PIN_21_CONFIG && idx <= `IDX_WD_CONTROL)
                         || idx == `IDX_DEVICE_ACTIVATE;
    wire [7:0] wd8     = avs_writedata_i[7:0];

    //------------------------------------------------------------
    // pin configuration, one slice per pin (2.1 .. 2.5)
    //------------------------------------------------------------
    wire [4:0] pin_logic;
    wire [4:0] irq_src;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : pins
            localparam [31:0] MY_IDX = `IDX_PIN_21_CONFIG + g;
            wire [7:0] my_idx = MY_IDX[7:0];
            // pin 2.2 alone has the open-collector option, 2.5 the alt function
            wire [7:0] keep = (g == 1) ? 8'h87 : (g == 4) ? 8'h0f : 8'h07;
            always @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    pin_cfg_q[g] <= `PIN_CONFIG_RESET;
                end else if (wr_go && idx == my_idx) begin
                    pin_cfg_q[g] <= wd8 & keep;
                end
            end
            // pin level as seen by the register side, inverted if asked
            assign pin_logic[g] = pin_in_i[g] ^ pin_cfg_q[g][`PIN_POL_BIT];
            assign irq_src[g]   = pin_logic[g] & pin_cfg_q[g][`PIN_IRQ_EN_BIT];
            always @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    pin_out_o[g] <= 1'b0;
                    pin_oe_o[g]  <= 1'b0;
                    pin_rd_o[g]  <= 1'b0;
                end else begin
                    pin_rd_o[g] <= pin_logic[g];
                    if (g == 4 && pin_cfg_q[g][`PIN_ALT_BIT]) begin
                        pin_out_o[g] <= address_line_20_gate_i;
                        pin_oe_o[g]  <= 1'b1;
                    end else if (pin_cfg_q[g][`PIN_DIR_BIT]) begin
                        pin_out_o[g] <= 1'b0;
                        pin_oe_o[g]  <= 1'b0;
                    end else if (pin_cfg_q[g][`PIN_OC_BIT]) begin
                        // open collector: drive only the low level
                        pin_out_o[g] <= 1'b0;
                        pin_oe_o[g]  <= ~(pin_data_i[g] ^ pin_cfg_q[g][`PIN_POL_BIT]);
                    end else begin
                        pin_out_o[g] <= pin_data_i[g] ^ pin_cfg_q[g][`PIN_POL_BIT];
                        pin_oe_o[g]  <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    //------------------------------------------------------------
    // combined interrupt with optional debounce
    //------------------------------------------------------------
    wire       gp_raw = |irq_src;
    reg        gp_filt_q;
    reg [15:0] deb_cnt_q;
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gp_filt_q <= 1'b0;
            deb_cnt_q <= 16'h0000;
        end else if (gp_raw == gp_filt_q) begin
            deb_cnt_q <= 16'h0000;
        end else if (deb_cnt_q >= DEBOUNCE_CYC[15:0] - 16'h0001) begin
            gp_filt_q <= gp_raw;
            deb_cnt_q <= 16'h0000;
        end else begin
            deb_cnt_q <= deb_cnt_q + 16'h0001;
        end
    end
    wire gp_a = cirq_a_q[`CIRQ_FILTER_BIT] ? gp_filt_q : gp_raw;
    wire gp_b = cirq_b_q[`CIRQ_FILTER_BIT] ? gp_filt_q : gp_raw;

    //------------------------------------------------------------
    // watchdog timer
    //------------------------------------------------------------
    reg [25:0] unit_cnt_q;
    reg [7:0]  wd_cnt_q;
    reg        krst_q;
    wire       krst_rise = keyboard_reset_output_i & ~krst_q;
    wire [25:0] unit_len = dec_en_q[`DEC_UNIT_SEL_BIT] ? UNIT_LONG_CYC[25:0]
                                                       : UNIT_SHORT_CYC[25:0];
    wire       unit_tick = unit_cnt_q >= unit_len - 26'd1;
    wire       reload = (wd_cfg_q[`WCFG_GAME_BIT] & game_port_access_i)
                      | (wd_cfg_q[`WCFG_KBD_BIT] & keyboard_irq_i)
                      | (wd_cfg_q[`WCFG_MOUSE_BIT] & mouse_irq_i);
    wire       force_to = (wr_go && idx == `IDX_WD_CONTROL && wd8[`WCTL_FORCE_BIT])
                        | (wd_ctl_q[`WCTL_KRST_EN_BIT] & krst_rise);
    wire       expire = wd_val_q != 8'h00 && !wd_ctl_q[`WCTL_STATUS_BIT] && !reload
                        && unit_tick && wd_cnt_q == 8'h01;
    wire       val_wr = wr_go && idx == `IDX_WD_TIMEOUT_VALUE;

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unit_cnt_q <= 26'd0;
            wd_cnt_q   <= 8'h00;
            krst_q     <= 1'b0;
        end else begin
            krst_q <= keyboard_reset_output_i;
            if (reload || val_wr) begin
                unit_cnt_q <= 26'd0;
                wd_cnt_q   <= val_wr ? wd8 : wd_val_q;
            end else if (wd_val_q == 8'h00 || wd_ctl_q[`WCTL_STATUS_BIT]) begin
                unit_cnt_q <= 26'd0;
                wd_cnt_q   <= wd_val_q;
            end else if (unit_tick) begin
                unit_cnt_q <= 26'd0;
                wd_cnt_q   <= wd_cnt_q - 8'h01;
            end else begin
                unit_cnt_q <= unit_cnt_q + 26'd1;
            end
        end
    end

    //------------------------------------------------------------
    // power led blink, 1 Hz square wave
    //------------------------------------------------------------
    reg [24:0] led_cnt_q;
    reg        led_ph_q;
    wire       blink = wd_ctl_q[`WCTL_LED_BIT]
                     | (wd_cfg_q[`WCFG_LED_BIT] & wd_ctl_q[`WCTL_STATUS_BIT]);
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            led_cnt_q <= 25'd0;
            led_ph_q  <= 1'b0;
        end else if (!blink) begin
            led_cnt_q <= 25'd0;
            led_ph_q  <= 1'b0;
        end else if (led_cnt_q >= LED_HALF_CYC[24:0] - 25'd1) begin
            led_cnt_q <= 25'd0;
            led_ph_q  <= ~led_ph_q;
        end else begin
            led_cnt_q <= led_cnt_q + 25'd1;
        end
    end

    //------------------------------------------------------------
    // register writes
    //------------------------------------------------------------
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cirq_b_q   <= `REG_RESET_ZERO;
            cirq_a_q   <= `REG_RESET_ZERO;
            dec_en_q   <= `REG_RESET_ZERO;
            wd_val_q   <= `REG_RESET_ZERO;
            wd_cfg_q   <= `REG_RESET_ZERO;
            wd_ctl_q   <= 4'h0;
            activate_q <= 1'b0;
        end else begin
            if (wr_go && idx == `IDX_COMBINED_IRQ_B) cirq_b_q <= wd8 & 8'hf8;
            if (wr_go && idx == `IDX_COMBINED_IRQ_A) cirq_a_q <= wd8 & 8'hf8;
            if (wr_go && idx == `IDX_DECODER_STROBE_EN) dec_en_q <= wd8 & 8'h83;
            if (val_wr) wd_val_q <= wd8;
            if (wr_go && idx == `IDX_WD_CONFIG) wd_cfg_q <= wd8;
            if (wr_go && idx == `IDX_DEVICE_ACTIVATE) activate_q <= wd8[0];
            if (wr_go && idx == `IDX_WD_CONTROL) begin
                wd_ctl_q[`WCTL_LED_BIT]     <= wd8[`WCTL_LED_BIT];
                wd_ctl_q[`WCTL_KRST_EN_BIT] <= wd8[`WCTL_KRST_EN_BIT];
            end
            // timeout sets status and wins over a software clear
            if (expire || force_to) begin
                wd_ctl_q[`WCTL_STATUS_BIT] <= 1'b1;
            end else if (wr_go && idx == `IDX_WD_CONTROL) begin
                wd_ctl_q[`WCTL_STATUS_BIT] <= wd8[`WCTL_STATUS_BIT];
            end
            wd_ctl_q[`WCTL_FORCE_BIT] <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // outputs to the system
    //------------------------------------------------------------
    reg [15:0] irq_d;
    always @* begin
        irq_d = 16'h0000;
        if (cirq_a_q[7:4] != 4'h0) irq_d[cirq_a_q[7:4]] = gp_a;
        if (cirq_b_q[7:4] != 4'h0) irq_d[cirq_b_q[7:4]] = irq_d[cirq_b_q[7:4]] | gp_b;
        if (wd_cfg_q[7:4] != 4'h0)
            irq_d[wd_cfg_q[7:4]] = irq_d[wd_cfg_q[7:4]] | wd_ctl_q[`WCTL_STATUS_BIT];
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_irq_o                <= 16'h0000;
            power_indicator_led_o     <= 1'b0;
            general_address_decoder_o <= 1'b0;
            general_write_strobe_o    <= 1'b0;
        end else begin
            host_irq_o            <= irq_d;
            power_indicator_led_o <= blink & led_ph_q;
            general_address_decoder_o <= activate_q & dec_en_q[`DEC_ADDR_EN_BIT]
                                         & general_address_hit_i;
            general_write_strobe_o    <= activate_q & dec_en_q[`DEC_WSTB_EN_BIT]
                                         & general_write_hit_i;
        end
    end

    //------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then answer
    //------------------------------------------------------------
    reg [7:0] rd_d;
    always @* begin
        case (idx)
            `IDX_PIN_21_CONFIG:     rd_d = pin_cfg_q[0];
            `IDX_PIN_22_CONFIG:     rd_d = pin_cfg_q[1];
            `IDX_PIN_23_CONFIG:     rd_d = pin_cfg_q[2];
            `IDX_PIN_24_CONFIG:     rd_d = pin_cfg_q[3];
            `IDX_PIN_25_CONFIG:     rd_d = pin_cfg_q[4];
            `IDX_COMBINED_IRQ_B:    rd_d = cirq_b_q;
            `IDX_COMBINED_IRQ_A:    rd_d = cirq_a_q;
            `IDX_DECODER_STROBE_EN: rd_d = dec_en_q;
            `IDX_WD_TIMEOUT_VALUE:  rd_d = wd_val_q;
            `IDX_WD_CONFIG:         rd_d = wd_cfg_q;
            `IDX_WD_CONTROL:        rd_d = {4'h0, wd_ctl_q};
            `IDX_DEVICE_ACTIVATE:   rd_d = {7'h00, activate_q};
            default:                rd_d = 8'h00;
        endcase
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q           <= ST_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
            avs_response_o    <= RESP_OK;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        state_q           <= ST_RESP;
                        avs_waitrequest_o <= 1'b0;
                        avs_readdata_o    <= {24'h000000, avs_read_i ? rd_d : 8'h00};
                        avs_response_o    <= known ? RESP_OK : RESP_ERR;
                    end
                end
                ST_RESP: begin
                    state_q           <= ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                    avs_response_o    <= RESP_OK;
                end
                default: begin
                    state_q           <= ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* File: dv/pin_world.sv */
/*
 * far-side model of the board wiring of pins 2.1 to 2.5.
 * assumes a pull-up on every pin; the bench may drive a pin only while the block releases it.
 */
`timescale 1ns/1ps
module pin_world (
    input  wire [4:0] pin_out_i,
    input  wire [4:0] pin_oe_i,
    input  wire [4:0] ext_val_i,
    input  wire [4:0] ext_en_i,
    output wire [4:0] pin_level_o
);
    // a pin nobody drives floats up to the pull-up level
    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule

/* File: dv/aux_wd_checker.sv */
/*
 * concurrent checks on the ports of the aux pin and watchdog block.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
module aux_wd_checker #(
    parameter integer LED_HALF_CYC = 8
) (
    input wire        mclk_i,
    input wire        resetn_i,
    input wire [9:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    input wire [1:0]  avs_response_o,
    input wire        general_address_hit_i,
    input wire        general_write_hit_i,
    input wire        general_address_decoder_o,
    input wire        general_write_strobe_o,
    input wire        power_indicator_led_o,
    input wire [15:0] host_irq_o
);
    reg  [31:0] on_q;
    wire [7:0]  idx   = avs_address_i[9:2];
    wire        known = (idx >= 8'he9 && idx <= 8'hf4) || idx == 8'h30;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    // length of the current lit phase of the led
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i)
            on_q <= 32'h0;
        else if (power_indicator_led_o)
            on_q <= on_q + 32'h1;
        else
            on_q <= 32'h0;
    end
    a_answer_one_cycle: assert property (s_taken |=> s_answer)
        else $error("bus request not answered for exactly one cycle");
    a_unmapped_refused: assert property ((s_taken ##0 (!known && idx != 8'hee)) |=>
        (avs_response_o == 2'b10 && avs_readdata_o == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property ((s_taken ##0 known) |=> avs_response_o == 2'b00)
        else $error("mapped access answered with error");
    a_upper_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_idle_resp_ok: assert property (avs_waitrequest_o |-> avs_response_o == 2'b00)
        else $error("response shown outside an answer");
    a_irq_line_zero: assert property (host_irq_o[0] == 1'b0)
        else $error("host line zero driven");
    a_decoder_gated: assert property (general_address_decoder_o |-> $past(general_address_hit_i))
        else $error("decoder output without a hit");
    a_strobe_gated: assert property (general_write_strobe_o |-> $past(general_write_hit_i))
        else $error("write strobe without a hit");
    a_led_half_phase: assert property ($fell(power_indicator_led_o) |-> on_q == LED_HALF_CYC)
        else $error("led lit phase has wrong length");
endmodule
bind aux_gpio_and_watchdog_timer aux_wd_checker #(.LED_HALF_CYC(LED_HALF_CYC)) u_chk (
    .mclk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
    .avs_waitrequest_o, .avs_response_o, .general_address_hit_i, .general_write_hit_i,
    .general_address_decoder_o, .general_write_strobe_o, .power_indicator_led_o, .host_irq_o
);

/* File: dv/tb_top.sv */
/*
 * self-checking bench for the aux pin and watchdog block.
 * assumes the shortened unit and led counts set at the instance below.
 */
`timescale 1ns/1ps
module tb_top;
    reg         mclk_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg  [9:0]  adr = 10'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wd = 32'h0;
    reg  [4:0]  pdat = 5'h0;
    reg  [4:0]  ext = 5'h0;
    reg  [4:0]  ext_en = 5'h0;
    reg         a20 = 1'b0;
    reg         krst = 1'b0;
    reg         ahit = 1'b0;
    reg         whit = 1'b0;
    reg  [2:0]  evt = 3'h0;
    wire [31:0] rdata;
    wire        wreq;
    wire        led;
    wire        adec;
    wire        wstb;
    wire [1:0]  resp;
    wire [4:0]  pin_in;
    wire [4:0]  pout;
    wire [4:0]  poe;
    wire [4:0]  prd;
    wire [15:0] irq;
    integer     failures = 0;
    integer     cmp_count = 0;
    reg  [7:0]  r;
    reg  [1:0]  rs;
    always #25 mclk_i = ~mclk_i;
    aux_gpio_and_watchdog_timer #(.UNIT_SHORT_CYC(10), .UNIT_LONG_CYC(20), .LED_HALF_CYC(8), .DEBOUNCE_CYC(4)) u_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .avs_response_o(resp), .pin_in_i(pin_in), .pin_data_i(pdat), .pin_out_o(pout), .pin_oe_o(poe),
        .pin_rd_o(prd), .address_line_20_gate_i(a20), .game_port_access_i(evt[0]), .keyboard_irq_i(evt[1]),
        .mouse_irq_i(evt[2]), .keyboard_reset_output_i(krst), .general_address_hit_i(ahit),
        .general_write_hit_i(whit), .general_address_decoder_o(adec), .general_write_strobe_o(wstb),
        .power_indicator_led_o(led), .host_irq_o(irq));
    pin_world u_pins (.pin_out_i(pout), .pin_oe_i(poe), .ext_val_i(ext), .ext_en_i(ext_en), .pin_level_o(pin_in));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task complete_run;
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        integer n;
        @(posedge mclk_i);
        adr <= {idx, 2'b00};
        wd <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        n = 0;
        do begin
            @(posedge mclk_i);
            n = n + 1;
        end while (wreq !== 1'b0 && n < 20);
        r = rdata[7:0];
        rs = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            failures = failures + 1;
            complete_run;
        end
    endtask
    function logic pick(input integer s);
        pick = (s == 16) ? led : irq[s];
    endfunction
    task reach(input integer s, input logic v, input integer n);
        integer k;
        for (k = 0; k < n && pick(s) !== v; k = k + 1)
            @(posedge mclk_i);
        chk("output reached", {7'h0, pick(s)}, {7'h0, v});
    endtask
    task stay(input integer s, input logic v, input integer n);
        integer k;
        for (k = 0; k < n && pick(s) === v; k = k + 1)
            @(posedge mclk_i);
        chk("output held", {7'h0, pick(s)}, {7'h0, v});
    endtask
    task do_reset;
        resetn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        integer i;
        for (i = 8'he9; i <= 8'hf4; i = i + 1) begin
            bus(1'b0, i[7:0], 8'h00);
            chk("reset value", r, (i < 8'hee) ? 8'h01 : 8'h00);
        end
        bus(1'b0, 8'h00, 8'h00);
        chk("unmapped response", {6'h0, rs}, 8'h02);
        chk("unmapped data", r, 8'h00);
    endtask
    task t_masks;
        integer i;
        logic [7:0] m [0:8];
        m = '{8'h07, 8'h87, 8'h07, 8'h07, 8'h0f, 8'h00, 8'hf8, 8'hf8, 8'h83};
        for (i = 0; i < 9; i = i + 1) begin
            bus(1'b1, 8'he9 + i[7:0], 8'hff);
            bus(1'b0, 8'he9 + i[7:0], 8'h00);
            chk("writable bits", r, m[i]);
        end
    endtask
    task t_pins;
        bus(1'b1, 8'heb, 8'h02);
        pdat <= 5'h04;
        repeat (2) @(posedge mclk_i);
        chk("inverted drive", {6'h0, poe[2], pout[2]}, 8'h02);
        bus(1'b1, 8'hea, 8'h00);
        pdat <= 5'h02;
        repeat (2) @(posedge mclk_i);
        chk("push pull high", {6'h0, poe[1], pout[1]}, 8'h03);
        chk("inverted read back", {7'h0, prd[2]}, 8'h01);
        bus(1'b1, 8'hea, 8'h80);
        repeat (2) @(posedge mclk_i);
        chk("open collector release", {7'h0, poe[1]}, 8'h00);
        pdat <= 5'h00;
        repeat (2) @(posedge mclk_i);
        chk("open collector sink", {6'h0, poe[1], pout[1]}, 8'h02);
        bus(1'b1, 8'hed, 8'h08);
        a20 <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk("gate high", {7'h0, pout[4]}, 8'h01);
        a20 <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("gate low", {7'h0, pout[4]}, 8'h00);
    endtask
    task t_cirq;
        integer i;
        logic [3:0] ln [0:2];
        ln = '{4'h1, 4'h5, 4'hf};
        ext_en <= 5'h08;
        bus(1'b1, 8'hec, 8'h05);
        bus(1'b1, 8'hf0, 8'h50);
        stay(5, 1'b0, 4);
        ext <= 5'h08;
        for (i = 0; i < 3; i = i + 1) begin
            bus(1'b1, 8'hf0, {ln[i], 4'h0});
            reach(ln[i], 1'b1, 6);
        end
        bus(1'b1, 8'hf0, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk("route disabled", irq[7:0] | irq[15:8], 8'h00);
        bus(1'b1, 8'hec, 8'h01);
        bus(1'b1, 8'hf0, 8'h50);
        stay(5, 1'b0, 10);
        bus(1'b1, 8'hf0, 8'h00);
        bus(1'b1, 8'hec, 8'h05);
        ext <= 5'h00;
        bus(1'b1, 8'hef, 8'h68);
        ext <= 5'h08;
        stay(6, 1'b0, 4);
        reach(6, 1'b1, 12);
        bus(1'b1, 8'hef, 8'h00);
        ext_en <= 5'h00;
    endtask
    task t_dec;
        bus(1'b1, 8'h30, 8'h00);
        bus(1'b1, 8'hf1, 8'h03);
        ahit <= 1'b1;
        whit <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk("inactive gating", {6'h0, adec, wstb}, 8'h00);
        bus(1'b1, 8'h30, 8'h01);
        repeat (2) @(posedge mclk_i);
        chk("active gating", {6'h0, adec, wstb}, 8'h03);
        bus(1'b1, 8'hf1, 8'h01);
        repeat (2) @(posedge mclk_i);
        chk("strobe disabled", {6'h0, adec, wstb}, 8'h02);
        ahit <= 1'b0;
        whit <= 1'b0;
    endtask
    task t_wd;
        bus(1'b1, 8'hf1, 8'h00);
        bus(1'b1, 8'hf3, 8'h30);
        bus(1'b1, 8'hf2, 8'h02);
        stay(3, 1'b0, 19);
        reach(3, 1'b1, 15);
        bus(1'b0, 8'hf4, 8'h00);
        chk("timeout status", r, 8'h01);
        bus(1'b1, 8'hf2, 8'h00);
        bus(1'b1, 8'hf4, 8'h00);
        reach(3, 1'b0, 4);
        bus(1'b1, 8'hf1, 8'h80);
        bus(1'b1, 8'hf2, 8'h02);
        stay(3, 1'b0, 19);
        reach(3, 1'b1, 25);
        bus(1'b1, 8'hf2, 8'h00);
        bus(1'b1, 8'hf4, 8'h00);
        repeat (2) @(posedge mclk_i);
        stay(3, 1'b0, 60);
        bus(1'b1, 8'hf1, 8'h00);
    endtask
    task t_reload;
        integer k;
        integer j;
        for (k = 0; k < 3; k = k + 1) begin
            bus(1'b1, 8'hf3, 8'h30 | (8'h01 << k));
            bus(1'b1, 8'hf2, 8'h02);
            for (j = 0; j < 6; j = j + 1) begin
                evt[k] <= 1'b1;
                @(posedge mclk_i);
                evt[k] <= 1'b0;
                stay(3, 1'b0, 7);
            end
            bus(1'b1, 8'hf3, 8'h30);
            evt[k] <= 1'b1;
            reach(3, 1'b1, 30);
            evt[k] <= 1'b0;
            bus(1'b1, 8'hf2, 8'h00);
            bus(1'b1, 8'hf4, 8'h00);
        end
    endtask
    task t_force;
        bus(1'b1, 8'hf4, 8'h04);
        reach(3, 1'b1, 4);
        bus(1'b0, 8'hf4, 8'h00);
        chk("force self clear", r, 8'h01);
        bus(1'b1, 8'hf4, 8'h08);
        krst <= 1'b1;
        reach(3, 1'b1, 6);
        bus(1'b1, 8'hf4, 8'h08);
        repeat (2) @(posedge mclk_i);
        stay(3, 1'b0, 20);
        krst <= 1'b0;
        bus(1'b1, 8'hf4, 8'h00);
        krst <= 1'b1;
        stay(3, 1'b0, 20);
        krst <= 1'b0;
    endtask
    task t_led;
        bus(1'b1, 8'hf4, 8'h02);
        reach(16, 1'b1, 20);
        reach(16, 1'b0, 12);
        bus(1'b1, 8'hf4, 8'h00);
        stay(16, 1'b0, 30);
        bus(1'b1, 8'hf3, 8'h08);
        stay(16, 1'b0, 20);
        bus(1'b1, 8'hf4, 8'h04);
        reach(16, 1'b1, 20);
        reach(16, 1'b0, 12);
        reach(16, 1'b1, 12);
    endtask
    initial begin
        do_reset;
        t_regs;
        t_masks;
        do_reset;
        t_regs;
        t_pins;
        t_cirq;
        t_dec;
        t_wd;
        t_reload;
        t_force;
        t_led;
        complete_run;
    end
endmodule
